// [rx_word_aligner_map.vh]
// Purpose : Constants for the receive word aligner.
// Assumes : Included by bare name from the aligner design files.
// Notes   : Definitions only.
`ifndef RX_WORD_ALIGNER_MAP_VH
`define RX_WORD_ALIGNER_MAP_VH

// =====================================================================
// Operating modes
`define MODE_MANUAL      2'h0
`define MODE_BITSLIP     2'h1
`define MODE_AUTO        2'h2
`define MODE_RSVD        2'h3

// =====================================================================
// Interface widths and pattern lengths
`define WORD_W10         10
`define WORD_W8          8
`define PAT_LEN16        16
`define PAT_LEN10        10
`define PAT_LEN7         7
`define STREAM_W         30
`define OFS_W            4
`define SLIP_W           5

// =====================================================================
// Automatic sync machine states and defaults
`define SYNC_ST_LOSS     1'h0
`define SYNC_ST_LOCK     1'h1
`define SYNC_PATS_DEF    3
`define LOSS_PATS_DEF    4
`define CNT_W            4

`endif

// [rx_align_search.v]
// Purpose : Scans a three-word history for the alignment pattern at every
//           bit offset and reports the lowest matching offset.
// Assumes : Oldest word sits in the low bits of the history, LSB first.
// Notes   : Result is registered, one cycle behind the history it saw.
`timescale 1ns/10ps
`include "rx_word_aligner_map.vh"

module rx_align_search (
  // Clock and reset
  input  wire                  i_mclk,
  input  wire                  i_reset_n,
  // Search inputs
  input  wire [`STREAM_W-1:0]  i_stream,
  input  wire [`PAT_LEN16-1:0] i_pattern,
  input  wire                  i_width_10,
  input  wire                  i_pat_len_7,
  // Search result
  output reg                   o_hit_ff,
  output reg  [`OFS_W-1:0]     o_offset_ff
);

  // ===================================================================
  // Pattern compare
  // Complement match only exists for the 10-bit interface.
  function match;
    input [`PAT_LEN16-1:0] seg;
    input [`PAT_LEN16-1:0] pat;
    input                  w10;
    input                  len7;
    reg   [`PAT_LEN16-1:0] mask;
    begin
      if (!w10) begin
        mask = 16'hFFFF;
      end else if (len7) begin
        mask = 16'h007F;
      end else begin
        mask = 16'h03FF;
      end
      match = ((seg & mask) == (pat & mask)) ||
              (w10 && ((~seg & mask) == (pat & mask)));
    end
  endfunction

  // ===================================================================
  // One comparator per candidate offset
  wire [`WORD_W10-1:0] hit_vec;

  genvar k;
  generate
    for (k = 0; k < `WORD_W10; k = k + 1) begin : g_ofs
      assign hit_vec[k] = ((k < `WORD_W8) || i_width_10) &&
                          match(i_stream[k+`PAT_LEN16-1:k], i_pattern,
                                i_width_10, i_pat_len_7);
    end
  endgenerate

  // ===================================================================
  // Lowest offset wins
  reg              nxt_hit;
  reg [`OFS_W-1:0] nxt_offset;
  integer          i;

  always @* begin
    nxt_hit    = 1'b0;
    nxt_offset = 4'h0;
    for (i = `WORD_W10 - 1; i >= 0; i = i - 1) begin
      if (hit_vec[i]) begin
        nxt_hit    = 1'b1;
        nxt_offset = i[`OFS_W-1:0];
      end
    end
  end

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hit_ff    <= 1'b0;
      o_offset_ff <= 4'h0;
    end else begin
      o_hit_ff    <= nxt_hit;
      o_offset_ff <= nxt_offset;
    end
  end

endmodule

// [rx_word_aligner.v]
// Purpose : Receive word aligner with manual, bit-slip and automatic modes.
// Assumes : One word per clock, LSB received first; inputs synchronous.
// Notes   : Output word and pattern detect lag the input word by five clocks.
`timescale 1ns/10ps
`include "rx_word_aligner_map.vh"

module rx_word_aligner #(
  parameter SYNC_PATS = `SYNC_PATS_DEF,
  parameter LOSS_PATS = `LOSS_PATS_DEF
) (
  // Clock and resets
  input  wire                  i_mclk,
  input  wire                  i_reset_n,
  input  wire                  i_rx_digitalreset,
  // Configuration
  input  wire [1:0]            i_mode,
  input  wire                  i_width_10,
  input  wire                  i_pat_len_7,
  input  wire [`PAT_LEN16-1:0] i_pattern,
  // User control
  input  wire                  i_enapatternalign,
  input  wire                  i_bitslip,
  // Deserializer data
  input  wire [`WORD_W10-1:0]  i_rx_data,
  // Aligned data and status
  output reg  [`WORD_W10-1:0]  o_rx_data_ff,
  output reg                   o_aligned_ff,
  output reg                   o_pattern_det_ff,
  output reg  [`SLIP_W-1:0]    o_slip_count_ff,
  output reg                   o_mode_err_ff
);

  // ===================================================================
  // Word history, oldest word in the low bits
  reg  [`WORD_W10-1:0] word0_ff;
  reg  [`WORD_W10-1:0] word1_ff;
  reg  [`WORD_W10-1:0] word2_ff;
  reg  [`STREAM_W-1:0] stream;

  always @* begin
    if (i_width_10) begin
      stream = {word0_ff, word1_ff, word2_ff};
    end else begin
      stream = {6'h00, word0_ff[7:0], word1_ff[7:0], word2_ff[7:0]};
    end
  end

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word0_ff <= 10'h000;
      word1_ff <= 10'h000;
      word2_ff <= 10'h000;
    end else begin
      word0_ff <= i_rx_data;
      word1_ff <= word0_ff;
      word2_ff <= word1_ff;
    end
  end

  // Delayed copy so extraction lines up with the registered search
  reg  [`STREAM_W-1:0] stream_d_ff;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stream_d_ff <= 30'h00000000;
    end else begin
      stream_d_ff <= stream;
    end
  end

  // ===================================================================
  // Pattern search
  wire              hit;
  wire [`OFS_W-1:0] hit_ofs;

  rx_align_search u_search (
    .i_mclk      (i_mclk),
    .i_reset_n   (i_reset_n),
    .i_stream    (stream),
    .i_pattern   (i_pattern),
    .i_width_10  (i_width_10),
    .i_pat_len_7 (i_pat_len_7),
    .o_hit_ff    (hit),
    .o_offset_ff (hit_ofs)
  );

  // ===================================================================
  // Helpers
  function [`WORD_W10-1:0] pick;
    input [`STREAM_W-1:0] s;
    input [`OFS_W-1:0]    k;
    reg   [`STREAM_W-1:0] t;
    begin
      t    = s >> k;
      pick = t[`WORD_W10-1:0];
    end
  endfunction

  function [`OFS_W-1:0] next_ofs;
    input [`OFS_W-1:0] k;
    input              w10;
    begin
      if ((w10 && k == 4'h9) || (!w10 && k == 4'h7)) begin
        next_ofs = 4'h0;
      end else begin
        next_ofs = k + 4'h1;
      end
    end
  endfunction

  // ===================================================================
  // Edge detection on user controls
  reg  ena_prev_ff;
  reg  slip_prev_ff;
  wire ena_rise  = i_enapatternalign & ~ena_prev_ff;
  wire slip_rise = i_bitslip & ~slip_prev_ff;

  // Preset high during reset, so an enable level held across release
  // does not count as an edge.
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ena_prev_ff  <= 1'b1;
      slip_prev_ff <= 1'b1;
    end else begin
      ena_prev_ff  <= i_enapatternalign;
      slip_prev_ff <= i_bitslip;
    end
  end

  // ===================================================================
  // Alignment control
  reg  [`OFS_W-1:0] boundary_ff;
  reg  [`OFS_W-1:0] nxt_boundary;
  reg               aligned_ff;
  reg               nxt_aligned;
  reg               pend_ff;
  reg               nxt_pend;
  reg               sync_st_ff;
  reg               nxt_sync_st;
  reg  [`CNT_W-1:0] cnt_ff;
  reg  [`CNT_W-1:0] nxt_cnt;
  reg  [`OFS_W-1:0] cand_ff;
  reg  [`OFS_W-1:0] nxt_cand;

  wire mode_bad  = (i_mode == `MODE_RSVD) ||
                   (i_mode == `MODE_AUTO && !i_width_10);
  wire same_hit  = hit && (hit_ofs == boundary_ff);
  wire other_hit = hit && (hit_ofs != boundary_ff);

  always @* begin
    nxt_boundary = boundary_ff;
    nxt_aligned  = aligned_ff;
    nxt_pend     = pend_ff;
    nxt_sync_st  = sync_st_ff;
    nxt_cnt      = cnt_ff;
    nxt_cand     = cand_ff;
    if (i_rx_digitalreset) begin
      nxt_boundary = 4'h0;
      nxt_aligned  = 1'b0;
      nxt_pend     = 1'b0;
      nxt_sync_st  = `SYNC_ST_LOSS;
      nxt_cnt      = 4'h0;
      nxt_cand     = 4'h0;
    end else if (mode_bad) begin
      nxt_aligned = 1'b0;
      nxt_pend    = 1'b0;
    end else begin
      case (i_mode)
        `MODE_MANUAL: begin
          if (!i_width_10) begin
            if (ena_rise) begin
              nxt_pend = 1'b1;
            end
            // realign only on a new edge
            if ((pend_ff || ena_rise) && hit) begin
              nxt_boundary = hit_ofs;
              nxt_aligned  = 1'b1;
              nxt_pend     = 1'b0;
            end
          end else begin
            if (i_enapatternalign && hit) begin
              nxt_boundary = hit_ofs;
              nxt_aligned  = 1'b1;
            end
            nxt_pend = 1'b0;
          end
        end
        `MODE_BITSLIP: begin
          if (slip_rise) begin
            nxt_boundary = next_ofs(boundary_ff, i_width_10);
          end
          nxt_aligned = same_hit;
          nxt_pend    = 1'b0;
        end
        `MODE_AUTO: begin
          case (sync_st_ff)
            `SYNC_ST_LOSS: begin
              nxt_aligned = 1'b0;
              if (hit) begin
                if (hit_ofs == cand_ff && cnt_ff != 4'h0) begin
                  nxt_cnt = cnt_ff + 4'h1;
                end else begin
                  nxt_cnt = 4'h1;
                end
                nxt_cand = hit_ofs;
                if (hit_ofs == cand_ff && cnt_ff + 4'h1 >= SYNC_PATS[3:0]) begin
                  nxt_boundary = hit_ofs;
                  nxt_sync_st  = `SYNC_ST_LOCK;
                  nxt_aligned  = 1'b1;
                  nxt_cnt      = 4'h0;
                end
              end
            end
            `SYNC_ST_LOCK: begin
              nxt_aligned = 1'b1;
              // Repeated patterns elsewhere mean the boundary slipped
              if (same_hit) begin
                nxt_cnt = 4'h0;
              end else if (other_hit) begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff + 4'h1 >= LOSS_PATS[3:0]) begin
                  nxt_sync_st = `SYNC_ST_LOSS;
                  nxt_aligned = 1'b0;
                  nxt_cnt     = 4'h0;
                end
              end
            end
            default: begin
              nxt_sync_st = `SYNC_ST_LOSS;
            end
          endcase
          nxt_pend = 1'b0;
        end
        default: begin
          nxt_pend = 1'b0;
        end
      endcase
    end
  end

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      boundary_ff <= 4'h0;
      aligned_ff  <= 1'b0;
      pend_ff     <= 1'b0;
      sync_st_ff  <= `SYNC_ST_LOSS;
      cnt_ff      <= 4'h0;
      cand_ff     <= 4'h0;
    end else begin
      boundary_ff <= nxt_boundary;
      aligned_ff  <= nxt_aligned;
      pend_ff     <= nxt_pend;
      sync_st_ff  <= nxt_sync_st;
      cnt_ff      <= nxt_cnt;
      cand_ff     <= nxt_cand;
    end
  end

  // ===================================================================
  // Outputs
  wire [`WORD_W10-1:0] word_out = pick(stream_d_ff, boundary_ff);

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx_data_ff     <= 10'h000;
      o_aligned_ff     <= 1'b0;
      o_pattern_det_ff <= 1'b0;
      o_slip_count_ff  <= 5'h00;
      o_mode_err_ff    <= 1'b0;
    end else begin
      if (i_width_10) begin
        o_rx_data_ff <= word_out;
      end else begin
        o_rx_data_ff <= {2'h0, word_out[7:0]};
      end
      o_aligned_ff     <= aligned_ff;
      o_pattern_det_ff <= same_hit && !i_rx_digitalreset;
      o_slip_count_ff  <= {1'b0, boundary_ff};
      o_mode_err_ff    <= mode_bad;
    end
  end

endmodule

// [rx_word_aligner_properties.sv]
// Purpose : Port-level checks for the receive word aligner.
// Assumes : One clock domain, reset active low.
// Notes   : Bound to every aligner instance below the module.
`timescale 1ns/10ps
`include "rx_word_aligner_map.vh"

module rx_word_aligner_properties #(
  parameter SYNC_PATS = `SYNC_PATS_DEF,
  parameter LOSS_PATS = `LOSS_PATS_DEF
) (
  // Aligner inputs
  input wire                  i_mclk,
  input wire                  i_reset_n,
  input wire                  i_rx_digitalreset,
  input wire [1:0]            i_mode,
  input wire                  i_width_10,
  input wire                  i_pat_len_7,
  input wire [`PAT_LEN16-1:0] i_pattern,
  input wire                  i_enapatternalign,
  input wire                  i_bitslip,
  input wire [`WORD_W10-1:0]  i_rx_data,
  // Aligner outputs
  input wire [`WORD_W10-1:0]  o_rx_data_ff,
  input wire                  o_aligned_ff,
  input wire                  o_pattern_det_ff,
  input wire [`SLIP_W-1:0]    o_slip_count_ff,
  input wire                  o_mode_err_ff
);
  reg  [3:0] en_age_ff;
  wire       man10;
  wire       bad_mode;

  assign man10    = (i_mode == `MODE_MANUAL) && i_width_10 && !i_rx_digitalreset;
  assign bad_mode = (i_mode == `MODE_RSVD) || ((i_mode == `MODE_AUTO) && !i_width_10);

  // Saturates so an old enable never looks recent
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_age_ff <= 4'hF;
    end else if (i_enapatternalign) begin
      en_age_ff <= 4'h0;
    end else if (en_age_ff != 4'hF) begin
      en_age_ff <= en_age_ff + 4'h1;
    end
  end

  // =====
  // Assertions
  default clocking dc @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  dreset_clears_a:
  assert property (i_rx_digitalreset [*4] |=> !o_aligned_ff && (o_slip_count_ff == 5'h00))
    else $error("digital reset left the aligner aligned");
  slip_range_a:
  assert property (o_slip_count_ff <= 5'h09) else $error("slip count out of range");
  mode_err_set_a:
  assert property (bad_mode [*3] |-> o_mode_err_ff) else $error("illegal mode not flagged");
  mode_ok_a:
  assert property (!bad_mode [*3] |-> !o_mode_err_ff) else $error("legal mode flagged");
  hold_low_a:
  assert property ((man10 && !i_enapatternalign) [*4] |-> $stable(o_slip_count_ff))
    else $error("boundary moved with enable low");
  align_cause_a:
  assert property (man10 && $rose(o_aligned_ff) |-> i_enapatternalign || (en_age_ff < 4'h8))
    else $error("aligned without the enable level");
  upper_zero_a:
  assert property (!i_width_10 [*6] |-> o_rx_data_ff[9:8] == 2'h0)
    else $error("upper bits set at 8-bit width");
  slip_step_a:
  assert property ($rose(i_bitslip) && (i_mode == `MODE_BITSLIP) && !i_rx_digitalreset
    |-> ##[1:6] !$stable(o_slip_count_ff)) else $error("bit-slip edge ignored");

  cover property (man10 && $rose(o_aligned_ff));
  cover property ($rose(o_mode_err_ff));
  cover property ((i_mode == `MODE_AUTO) && $rose(o_aligned_ff));
endmodule

bind rx_word_aligner rx_word_aligner_properties #(
  .SYNC_PATS(SYNC_PATS), .LOSS_PATS(LOSS_PATS)
) u_props (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_rx_digitalreset(i_rx_digitalreset),
  .i_mode(i_mode), .i_width_10(i_width_10), .i_pat_len_7(i_pat_len_7),
  .i_pattern(i_pattern), .i_enapatternalign(i_enapatternalign), .i_bitslip(i_bitslip),
  .i_rx_data(i_rx_data), .o_rx_data_ff(o_rx_data_ff), .o_aligned_ff(o_aligned_ff),
  .o_pattern_det_ff(o_pattern_det_ff), .o_slip_count_ff(o_slip_count_ff),
  .o_mode_err_ff(o_mode_err_ff)
);

// [rx_serial_source.sv]
// Purpose : Deserializer stand-in feeding words to the aligner.
// Assumes : Bit 0 of each word is the oldest bit.
// Notes   : Zero filler; a new send overwrites any unsent bits.
`timescale 1ns/10ps

module rx_serial_source (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_reset_n,
  // Bench control
  input  wire        i_width_10,
  input  wire        i_send,
  input  wire [15:0] i_pattern,
  input  wire [3:0]  i_offset,
  // Deserializer words
  output reg  [9:0]  o_word_ff
);
  reg [39:0] bits_ff;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bits_ff   <= 40'h0;
      o_word_ff <= 10'h000;
    end else if (i_send) begin
      bits_ff <= {24'h0, i_pattern} << i_offset;
    end else if (i_width_10) begin
      o_word_ff <= bits_ff[9:0];
      bits_ff   <= bits_ff >> 10;
    end else begin
      // Unused lanes keep toggling so nothing may rely on them
      o_word_ff <= {~o_word_ff[9:8], bits_ff[7:0]};
      bits_ff   <= bits_ff >> 8;
    end
  end
endmodule

// [test_rx_word_aligner.sv]
// Purpose : Self-checking bench for the receive word aligner.
// Assumes : Inputs driven on the rising edge, outputs read on the falling.
// Notes   : Patterns chosen so no shifted copy matches by accident.
`timescale 1ns/10ps

module test_rx_word_aligner;
  localparam logic [15:0] PAT10  = 16'h02E7;
  localparam logic [15:0] PAT16  = 16'hA5C3;
  localparam int          SYNC_N = 3;

  logic        i_mclk;
  logic        i_reset_n;
  logic        i_rx_digitalreset;
  logic [1:0]  i_mode;
  logic        i_width_10;
  logic [15:0] i_pattern;
  logic        i_pat_len_7;
  logic        i_enapatternalign;
  logic        i_bitslip;
  logic        send;
  logic [15:0] send_pat;
  logic [3:0]  send_ofs;
  wire  [9:0]  rx_word;
  wire  [9:0]  o_rx_data_ff;
  wire         o_aligned_ff;
  wire         o_pattern_det_ff;
  wire  [4:0]  o_slip_count_ff;
  wire         o_mode_err_ff;
  int          errors;
  int          tests_run;

  rx_serial_source u_src (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_width_10(i_width_10),
    .i_send(send), .i_pattern(send_pat), .i_offset(send_ofs), .o_word_ff(rx_word));
  rx_word_aligner #(.SYNC_PATS(SYNC_N), .LOSS_PATS(4)) dut (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_rx_digitalreset(i_rx_digitalreset), .i_mode(i_mode),
    .i_width_10(i_width_10), .i_pat_len_7(i_pat_len_7), .i_pattern(i_pattern),
    .i_enapatternalign(i_enapatternalign), .i_bitslip(i_bitslip), .i_rx_data(rx_word),
    .o_rx_data_ff(o_rx_data_ff), .o_aligned_ff(o_aligned_ff),
    .o_pattern_det_ff(o_pattern_det_ff),
    .o_slip_count_ff(o_slip_count_ff), .o_mode_err_ff(o_mode_err_ff));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // =====
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic compare(input logic [9:0] got, input logic [9:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_state(input logic al, input logic [4:0] slip, input string what);
    @(negedge i_mclk);
    compare({9'h0, o_aligned_ff}, {9'h0, al}, what);
    compare({5'h0, o_slip_count_ff}, {5'h0, slip}, what);
  endtask

  // Long tail covers source delay plus the aligner pipeline
  task automatic send_at(input logic [15:0] pat, input logic [3:0] ofs);
    @(posedge i_mclk);
    send     <= 1'b1;
    send_pat <= pat;
    send_ofs <= ofs;
    @(posedge i_mclk);
    send <= 1'b0;
    tick(12);
  endtask

  // Word and detect looked at in the one cycle the pattern leaves the pipe
  task automatic check_word(input logic [15:0] pat, input logic [3:0] ofs,
                            input logic [9:0] exp, input logic det, input string what);
    @(posedge i_mclk);
    send     <= 1'b1;
    send_pat <= pat;
    send_ofs <= ofs;
    @(posedge i_mclk);
    send <= 1'b0;
    tick(6);
    @(negedge i_mclk);
    compare(o_rx_data_ff, exp, what);
    compare({9'h0, o_pattern_det_ff}, {9'h0, det}, what);
    tick(6);
  endtask

  task automatic configure(input logic [1:0] mode, input logic w10, input logic [15:0] pat);
    @(posedge i_mclk);
    i_mode            <= mode;
    i_width_10        <= w10;
    i_pattern         <= pat;
    i_rx_digitalreset <= 1'b1;
    tick(4);
    i_rx_digitalreset <= 1'b0;
    tick(2);
  endtask

  task automatic set_enable(input logic en);
    @(posedge i_mclk);
    i_enapatternalign <= en;
  endtask

  // =====
  // Scenarios
  task automatic test_manual10();
    configure(2'h0, 1'b1, PAT10);
    set_enable(1'b1);
    send_at(PAT10, 4'h3);
    check_state(1'b1, 5'h03, "manual10 align");
    check_word(PAT10, 4'h3, 10'h2E7, 1'b1, "manual10 word");
    set_enable(1'b0);
    check_word(PAT10, 4'h6, 10'h338, 1'b0, "manual10 hold word");
    check_state(1'b1, 5'h03, "manual10 hold");
    set_enable(1'b1);
    send_at(~PAT10 & 16'h03FF, 4'h6);
    check_state(1'b1, 5'h06, "manual10 complement");
    // Seven-bit length compares only the low bits of the programmed one
    @(posedge i_mclk);
    i_pat_len_7 <= 1'b1;
    send_at(16'h0067, 4'h5);
    check_state(1'b1, 5'h05, "manual10 7-bit");
    set_enable(1'b0);
    i_pat_len_7 <= 1'b0;
    $display("test manual10 done");
  endtask

  task automatic test_manual8();
    configure(2'h0, 1'b0, PAT16);
    set_enable(1'b1);
    send_at(PAT16, 4'h2);
    check_state(1'b1, 5'h02, "manual8 align");
    check_word(PAT16, 4'h5, 10'h018, 1'b0, "manual8 no edge word");
    check_state(1'b1, 5'h02, "manual8 no edge");
    set_enable(1'b0);
    set_enable(1'b1);
    send_at(PAT16, 4'h5);
    check_state(1'b1, 5'h05, "manual8 new edge");
    check_word(PAT16, 4'h5, 10'h0C3, 1'b1, "manual8 word");
    $display("test manual8 done");
  endtask

  task automatic test_dreset();
    configure(2'h0, 1'b0, PAT16);
    check_state(1'b0, 5'h00, "digital reset clears");
    send_at(PAT16, 4'h4);
    check_state(1'b0, 5'h00, "enable high through reset");
    set_enable(1'b0);
    $display("test dreset done");
  endtask

  task automatic test_modes();
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 2; w++) begin
        @(posedge i_mclk);
        i_mode     <= m[1:0];
        i_width_10 <= w[0];
        tick(4);
        @(negedge i_mclk);
        compare({9'h0, o_mode_err_ff}, {9'h0, (m == 3) || (m == 2 && w == 0)}, "mode");
      end
    end
    $display("test modes done");
  endtask

  task automatic test_bitslip();
    configure(2'h1, 1'b1, PAT10);
    for (int i = 1; i <= 10; i++) begin
      @(posedge i_mclk);
      i_bitslip <= 1'b1;
      @(posedge i_mclk);
      i_bitslip <= 1'b0;
      tick(6);
      @(negedge i_mclk);
      compare({5'h0, o_slip_count_ff}, {5'h0, 5'(i % 10)}, "bit-slip step");
    end
    $display("test bitslip done");
  endtask

  task automatic test_auto();
    configure(2'h2, 1'b1, PAT10);
    for (int i = 0; i < SYNC_N; i++) begin
      send_at(PAT10, 4'h7);
    end
    check_state(1'b1, 5'h07, "auto lock");
    $display("test auto done");
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    tick(4000);
    errors++;
    $display("MISMATCH at %0t ns: watchdog expired", $time);
    stop_test();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    i_reset_n = 1'b0;
    i_rx_digitalreset = 1'b0;
    i_mode = 2'h0;
    i_width_10 = 1'b1;
    i_pattern = 16'h0000;
    i_pat_len_7 = 1'b0;
    i_enapatternalign = 1'b0;
    i_bitslip = 1'b0;
    send = 1'b0;
    send_pat = 16'h0000;
    send_ofs = 4'h0;
    tick(10);
    i_reset_n <= 1'b1;
    tick(2);
    check_state(1'b0, 5'h00, "after reset");
    test_manual10();
    test_manual8();
    test_dreset();
    test_modes();
    test_bitslip();
    test_auto();
    stop_test();
  end
endmodule
